// *** common/srg_pkg.sv ***
// types shared by the serial rate generator
package srg_pkg;

  // ----------------------------------------------------------------------------
  // divide mode, one-hot
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_async_lo = 3'b001,
    mode_async_hi = 3'b010,
    mode_sync     = 3'b100
  } srg_mode_t;

  typedef logic [7:0] srg_byte_t;

endpackage : srg_pkg

// *** common/srg_regs.svh ***
// register map, field positions, reset values and divide ratios of the serial rate generator
`ifndef SRG_REGS_SVH
`define SRG_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets (one 32-bit word each)
// ----------------------------------------------------------------------------
`define SRG_TXCTL_OFS      5'h00
`define SRG_RXCTL_OFS      5'h04
`define SRG_DIV_OFS        5'h08
`define SRG_STAT_OFS       5'h0C
`define SRG_IDX_TXCTL      3'h0
`define SRG_IDX_RXCTL      3'h1
`define SRG_IDX_DIV        3'h2
`define SRG_IDX_STAT       3'h3

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SRG_TX_CLKSRC_BIT  7
`define SRG_TX_SYNC_BIT    4
`define SRG_TX_HSPEED_BIT  2
`define SRG_RX_PORTEN_BIT  7
`define SRG_ST_RXLVL_BIT   0
`define SRG_ST_SCLK_BIT    1
`define SRG_ST_TMR_LSB     8

// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define SRG_TXCTL_RST      8'h00
`define SRG_RXCTL_RST      8'h00
`define SRG_DIV_RST        8'h00
`define SRG_TXCTL_WMASK    8'hF5
`define SRG_RXCTL_WMASK    8'hF8
`define SRG_UNMAPPED_RD    32'h0000_0000

// ----------------------------------------------------------------------------
// oversample ticks per bit for each mode
// ----------------------------------------------------------------------------
`define SRG_RATIO_ASYNC_LO 64
`define SRG_RATIO_ASYNC_HI 16
`define SRG_RATIO_SYNC     4

`endif

// *** logic/srg_majority.sv ***
// three-sample majority detector for the serial receive input
`timescale 1ns/1ps
`default_nettype none

module srg_majority (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // sampling
  input  wire logic sample_en,
  input  wire logic din,
  // decided level
  output logic      level
);
  import srg_pkg::*;

  logic [2:0] smp_ff;
  logic       level_ff;
  logic       nxt_level;

  // ----------------------------------------------------------------------------
  // sample window and vote
  // ----------------------------------------------------------------------------
  // shift in one sample per enable; idle line is high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smp_ff <= 3'h7;
    end else if (sample_en) begin
      smp_ff <= {smp_ff[1:0], din};
    end
  end

  // two of three wins, so one noisy sample cannot flip the level
  always_comb begin
    nxt_level = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2]) | (smp_ff[1] & smp_ff[2]);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_ff <= 1'b1;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // window holds at most one high sample, so the vote must come out low
  sequence s_two_low;
    $countones(smp_ff) <= 1;
  endsequence

  AST_MAJORITY_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    s_two_low |=> !level)
    else $error("two low samples of three did not give a low level");

endmodule : srg_majority

`default_nettype wire

// *** logic/srg_top.sv ***
// serial port rate generator with register slave and receive majority detector
`timescale 1ns/1ps
`default_nettype none

`include "srg_regs.svh"

module srg_top #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // avalon-mm slave
  input  wire logic [4:0]   address,
  input  wire logic         read,
  input  wire logic         write,
  input  wire logic [31:0]  writedata,
  input  wire logic [3:0]   byteenable,
  output logic      [31:0]  readdata,
  output logic              waitrequest,
  // serial pins
  input  wire logic         serial_receive_input,
  input  wire logic         sclk_in,
  output logic              sclk_out,
  output logic              sclk_oe,
  // status from the shift logic
  input  wire logic         tx_shift_empty,
  input  wire logic [2:0]   rx_status,
  // rate, level and control outputs
  output logic              oversample_tick,
  output logic              bit_tick,
  output logic              rx_level,
  output srg_pkg::srg_byte_t txctl,
  output logic              port_enable
);
  import srg_pkg::*;

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  srg_byte_t        txctl_ff;
  srg_byte_t        rxctl_ff;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] tmr_ff;
  logic [5:0]       pre_ff;
  logic             wait_ff;
  logic [31:0]      rdata_ff;
  logic             osc_ff;
  logic             bit_ff;
  logic             sclk_ff;
  logic             sclk_oe_ff;
  logic             ext_q_ff;
  logic             rx_lvl;
  logic [2:0]       idx;
  logic             acc_wr;
  logic             restart;
  logic             osc_hit;
  logic             pre_last;
  logic             is_sync;
  logic             is_master;
  logic [5:0]       pre_lim;
  srg_mode_t        mode;
  logic [31:0]      nxt_rdata;

  assign idx     = address[4:2];
  assign acc_wr  = write && !wait_ff;
  assign restart = acc_wr && (idx == `SRG_IDX_DIV) && byteenable[0];
  assign is_sync   = txctl_ff[`SRG_TX_SYNC_BIT];
  assign is_master = txctl_ff[`SRG_TX_CLKSRC_BIT];

  // ----------------------------------------------------------------------------
  // bus handshake: one wait cycle, then the access completes
  // ----------------------------------------------------------------------------
  // waitrequest drops for exactly one cycle after a request is seen
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else if (wait_ff && (read || write)) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  // read mux; unused words read as zero
  always_comb begin
    nxt_rdata = `SRG_UNMAPPED_RD;
    unique case (idx)
      `SRG_IDX_TXCTL: nxt_rdata[7:0] = {txctl_ff[7:4], 1'b0, txctl_ff[2], tx_shift_empty, txctl_ff[0]};
      `SRG_IDX_RXCTL: nxt_rdata[7:0] = {rxctl_ff[7:3], rx_status};
      `SRG_IDX_DIV:   nxt_rdata[DIV_W-1:0] = div_ff;
      `SRG_IDX_STAT: begin
        nxt_rdata[`SRG_ST_RXLVL_BIT] = rx_lvl;
        nxt_rdata[`SRG_ST_SCLK_BIT]  = sclk_ff;
        nxt_rdata[`SRG_ST_TMR_LSB +: DIV_W] = tmr_ff;
      end
      default: nxt_rdata = `SRG_UNMAPPED_RD;
    endcase
  end

  // read data captured in the wait cycle and held while waitrequest is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= `SRG_UNMAPPED_RD;
    end else if (wait_ff && read) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------------
  // status bits of the shift logic are not stored here, only masked writable bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txctl_ff <= `SRG_TXCTL_RST;
    end else if (acc_wr && idx == `SRG_IDX_TXCTL && byteenable[0]) begin
      txctl_ff <= writedata[7:0] & `SRG_TXCTL_WMASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxctl_ff <= `SRG_RXCTL_RST;
    end else if (acc_wr && idx == `SRG_IDX_RXCTL && byteenable[0]) begin
      rxctl_ff <= writedata[7:0] & `SRG_RXCTL_WMASK;
    end
  end

  // 8-bit divisor shared by every mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_ff <= DIV_W'(`SRG_DIV_RST);
    end else if (restart) begin
      div_ff <= writedata[DIV_W-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // free-running period timer on the system clock
  // ----------------------------------------------------------------------------
  // a divisor write clears the timer so the new period starts now
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tmr_ff <= '0;
    end else if (restart) begin
      tmr_ff <= '0;
    end else if (tmr_ff == div_ff) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= tmr_ff + 1'b1;
    end
  end

  assign osc_hit = !restart && (tmr_ff == div_ff);

  // ----------------------------------------------------------------------------
  // mode select and prescaler
  // ----------------------------------------------------------------------------
  // high-speed select only matters while asynchronous
  always_comb begin
    if (is_sync) begin
      mode = mode_sync;
    end else if (txctl_ff[`SRG_TX_HSPEED_BIT]) begin
      mode = mode_async_hi;
    end else begin
      mode = mode_async_lo;
    end
  end

  always_comb begin
    unique case (mode)
      mode_async_lo: pre_lim = 6'(`SRG_RATIO_ASYNC_LO - 1);
      mode_async_hi: pre_lim = 6'(`SRG_RATIO_ASYNC_HI - 1);
      mode_sync:     pre_lim = 6'(`SRG_RATIO_SYNC - 1);
      default:       pre_lim = 6'(`SRG_RATIO_ASYNC_LO - 1);
    endcase
  end

  // >= so a mode change to a shorter ratio cannot overrun the count
  assign pre_last = osc_hit && (pre_ff >= pre_lim);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_ff <= '0;
    end else if (restart) begin
      pre_ff <= '0;
    end else if (pre_last) begin
      pre_ff <= '0;
    end else if (osc_hit) begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // tick outputs
  // ----------------------------------------------------------------------------
  // oversample clock only exists in asynchronous mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_ff <= 1'b0;
    end else begin
      osc_ff <= osc_hit && !is_sync;
    end
  end

  // pin is taken as synchronous, so no synchroniser is needed here
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_q_ff <= 1'b0;
    end else begin
      ext_q_ff <= sclk_in;
    end
  end

  // slave bit timing follows the external clock's rising edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_ff <= 1'b0;
    end else if (is_sync && !is_master) begin
      bit_ff <= sclk_in && !ext_q_ff;
    end else begin
      bit_ff <= pre_last;
    end
  end

  // master clock: half period is two oversample ticks, full period 4(n+1)
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_ff <= 1'b0;
    end else if (!(is_sync && is_master) || restart) begin
      sclk_ff <= 1'b0;
    end else if (osc_hit && pre_ff[0]) begin
      sclk_ff <= !sclk_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_oe_ff <= 1'b0;
    end else begin
      sclk_oe_ff <= is_sync && is_master;
    end
  end

  // ----------------------------------------------------------------------------
  // receive majority detector, one sample per generator period
  // ----------------------------------------------------------------------------
  srg_majority u_major (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .sample_en (osc_hit),
    .din       (serial_receive_input),
    .level     (rx_lvl)
  );

  assign readdata        = rdata_ff;
  assign waitrequest     = wait_ff;
  assign sclk_out        = sclk_ff;
  assign sclk_oe         = sclk_oe_ff;
  assign oversample_tick = osc_ff;
  assign bit_tick        = bit_ff;
  assign rx_level        = rx_lvl;
  assign txctl           = txctl_ff;
  assign port_enable     = rxctl_ff[`SRG_RX_PORTEN_BIT];

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // helper: oversample ticks since the last bit tick, invalid after a txctl write, cleared by a divisor write
  logic [6:0] osc_cnt_ff;
  logic       cnt_ok_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_cnt_ff <= '0;
      cnt_ok_ff  <= 1'b1;
    end else if (restart || (acc_wr && idx == `SRG_IDX_TXCTL)) begin
      osc_cnt_ff <= '0;
      cnt_ok_ff  <= !(acc_wr && idx == `SRG_IDX_TXCTL);
    end else if (pre_last) begin
      osc_cnt_ff <= '0;
      cnt_ok_ff  <= 1'b1;
    end else if (osc_hit) begin
      osc_cnt_ff <= osc_cnt_ff + 1'b1;
    end
  end

  sequence s_div_write;
    acc_wr && idx == `SRG_IDX_DIV && byteenable[0];
  endsequence

  sequence s_req_seen;
    wait_ff && (read || write);
  endsequence

  AST_DIV_WRITE_CLEARS: assert property (@(posedge sys_clk) disable iff (rst)
    s_div_write |=> tmr_ff == '0 && pre_ff == '0 && div_ff == $past(writedata[DIV_W-1:0]))
    else $error("divisor write did not restart the timer");

  AST_RESET_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> tmr_ff == '0 && pre_ff == '0)
    else $error("timer not zero after reset release");

  AST_TIMER_WRAP: assert property (@(posedge sys_clk) disable iff (rst)
    (tmr_ff == div_ff) && !restart |=> tmr_ff == '0 ##1 (div_ff == '0 || tmr_ff == 1 || $past(restart)))
    else $error("timer did not wrap at the divisor");

  AST_ASYNC_LO: assert property (@(posedge sys_clk) disable iff (rst)
    pre_last && cnt_ok_ff && mode == mode_async_lo |-> osc_cnt_ff == 7'd63)
    else $error("low speed bit tick not every 64 timer periods");

  AST_ASYNC_HI: assert property (@(posedge sys_clk) disable iff (rst)
    pre_last && cnt_ok_ff && mode == mode_async_hi |-> osc_cnt_ff == 7'd15)
    else $error("high speed bit tick not every 16 timer periods");

  AST_SYNC_RATIO: assert property (@(posedge sys_clk) disable iff (rst)
    pre_last && cnt_ok_ff && is_sync |-> osc_cnt_ff == 7'd3)
    else $error("sync bit tick not every 4 timer periods");

  AST_SLAVE_CLOCK: assert property (@(posedge sys_clk) disable iff (rst)
    is_sync && !is_master && $past(is_sync && !is_master) && bit_ff |-> $past(sclk_in && !ext_q_ff) && !sclk_oe_ff)
    else $error("slave bit tick not from the external clock");

  AST_MASTER_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
    is_sync && is_master |=> sclk_oe_ff)
    else $error("sync master does not drive the serial clock");

  AST_ASYNC_NO_CLK: assert property (@(posedge sys_clk) disable iff (rst)
    !is_sync |=> !sclk_oe_ff && !sclk_ff)
    else $error("serial clock driven in async mode");

  AST_BUS_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
    s_req_seen |=> !wait_ff ##1 wait_ff)
    else $error("waitrequest did not drop for exactly one cycle");

endmodule : srg_top

`default_nettype wire

// *** verification/srg_top_test.sv ***
// self-checking bench for the serial rate generator and its register slave
`timescale 1ns/1ps
`default_nettype none

`include "srg_regs.svh"

module srg_top_test;
  import srg_pkg::*;

  // ----------------------------------------------------------------------------
  // design signals, inputs driven from time zero
  // ----------------------------------------------------------------------------
  logic        sys_clk              = 1'b0;
  logic        rst                  = 1'b1;
  logic [4:0]  address              = 5'h00;
  logic        read                 = 1'b0;
  logic        write                = 1'b0;
  logic [31:0] writedata            = 32'h0000_0000;
  logic [3:0]  byteenable           = 4'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        serial_receive_input = 1'b1;
  logic        sclk_in              = 1'b0;
  logic        sclk_out;
  logic        sclk_oe;
  logic        tx_shift_empty       = 1'b1;
  logic [2:0]  rx_status            = 3'h5;
  logic        oversample_tick;
  logic        bit_tick;
  logic        rx_level;
  srg_byte_t   txctl;
  logic        port_enable;

  // ----------------------------------------------------------------------------
  // bench state: model registers, event counters, random source
  // ----------------------------------------------------------------------------
  int          failures     = 0;
  int          total_checks = 0;
  int          bt_cnt       = 0;
  int          os_cnt       = 0;
  logic        prev_sclk    = 1'b0;
  int unsigned seed         = 71;
  logic [7:0]  mdl_tx       = 8'h00;
  logic [7:0]  mdl_rx       = 8'h00;
  logic [7:0]  mdl_div      = 8'h00;

  srg_top #(.DIV_W(8)) uut (
    .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .serial_receive_input(serial_receive_input), .sclk_in(sclk_in), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .tx_shift_empty(tx_shift_empty), .rx_status(rx_status),
    .oversample_tick(oversample_tick), .bit_tick(bit_tick), .rx_level(rx_level),
    .txctl(txctl), .port_enable(port_enable)
  );

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // tick counters; sampled before the edge's own updates land
  always @(posedge sys_clk) begin
    if (bit_tick === 1'b1) bt_cnt++;
    if (oversample_tick === 1'b1) os_cnt++;
    prev_sclk <= sclk_out;
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic int unsigned xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= wd;
    byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        failures++;
        wrap_up();
      end
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // write through the bus and mirror it in the model (masks of the writable bits)
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] rd;
    bus(1'b1, a, d, be, rd);
    if (be[0]) begin
      case (a[4:2])
        3'h0: mdl_tx = d[7:0] & `SRG_TXCTL_WMASK;
        3'h1: mdl_rx = d[7:0] & `SRG_RXCTL_WMASK;
        3'h2: mdl_div = d[7:0];
        default: ;
      endcase
    end
  endtask : wr_reg

  task automatic rd_chk(input logic [4:0] a);
    logic [31:0] rd;
    logic [31:0] exp;
    bus(1'b0, a, 32'h0000_0000, 4'hF, rd);
    case (a[4:2])
      3'h0: exp = {24'h00_0000, mdl_tx | {6'h00, tx_shift_empty, 1'b0}};
      3'h1: exp = {24'h00_0000, mdl_rx | {5'h00, rx_status}};
      3'h2: exp = {24'h00_0000, mdl_div};
      default: exp = `SRG_UNMAPPED_RD;
    endcase
    check("register read", rd, exp);
  endtask : rd_chk

  // cycles until the next event of kind k: 0 bit tick, 1 oversample tick, 2 sclk edge
  task automatic gap(input int k, output int g);
    logic hit;
    g = 0;
    do begin
      @(posedge sys_clk);
      g++;
      hit = (k == 0) ? bit_tick : (k == 1) ? oversample_tick : (sclk_out ^ prev_sclk);
      if (g > 20000) begin
        failures++;
        wrap_up();
      end
    end while (hit !== 1'b1);
  endtask : gap

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  logic [7:0] mode_tx [4] = '{8'h00, 8'h04, 8'h90, 8'h94};
  int         ratio   [4] = '{`SRG_RATIO_ASYNC_LO, `SRG_RATIO_ASYNC_HI, `SRG_RATIO_SYNC, `SRG_RATIO_SYNC};
  logic [4:0] addrs   [7] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h14, 5'h18, 5'h1C};

  initial begin
    int n;
    int g;
    int c0;
    int hits;
    // reset for 10 cycles, outputs checked while it is held
    repeat (9) @(posedge sys_clk);
    check("reset outputs", {waitrequest, bit_tick, oversample_tick, sclk_oe, rx_level, port_enable},
          {1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    @(posedge sys_clk);
    rst <= 1'b0;
    foreach (addrs[i]) rd_chk(addrs[i]);
    // random writes to every word except the status word at 0x0C, unmapped places included
    foreach (addrs[i]) begin
      rx_status      <= 3'(xs() % 8);
      tx_shift_empty <= 1'(xs() % 2);
      wr_reg(addrs[i], xs(), 4'h1);
      rd_chk(addrs[i]);
      check("txctl pins", {txctl, port_enable}, {mdl_tx, mdl_rx[7]});
    end
    // byte lane 0 disabled: write ignored
    wr_reg(`SRG_DIV_OFS, 32'h0000_00A5, 4'hE);
    rd_chk(`SRG_DIV_OFS);
    // every mode with a small random divisor
    for (int m = 0; m < 4; m++) begin
      n = xs() % 4;
      wr_reg(`SRG_TXCTL_OFS, mode_tx[m], 4'h1);
      wr_reg(`SRG_DIV_OFS, n, 4'h1);
      gap(0, g);
      gap(0, g);
      check("bit period", g, ratio[m] * (n + 1));
      if (m < 2) begin
        gap(1, g);
        gap(1, g);
        check("oversample period", g, n + 1);
      end else begin
        gap(2, g);
        gap(2, g);
        check("sclk half period", g, 2 * (n + 1));
        check("sclk drive", {31'h0, sclk_oe}, 1);
        c0 = os_cnt;
        repeat (40) @(posedge sys_clk);
        check("oversample in sync", os_cnt - c0, 0);
      end
    end
    // sync slave: bit ticks only from the external clock
    wr_reg(`SRG_DIV_OFS, 0, 4'h1);
    wr_reg(`SRG_TXCTL_OFS, 8'h10, 4'h1);
    repeat (3) @(posedge sys_clk);
    check("slave drive", {31'h0, sclk_oe}, 0);
    c0 = bt_cnt;
    repeat (4) begin
      @(posedge sys_clk);
      sclk_in <= 1'b1;
      repeat (5) @(posedge sys_clk);
      sclk_in <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
    check("slave bit ticks", bt_cnt - c0, 4);
    // full 8-bit divisor; rewrite mid-period restarts the timer
    wr_reg(`SRG_TXCTL_OFS, 8'h04, 4'h1);
    wr_reg(`SRG_DIV_OFS, 32'hABCD_12FF, 4'h1);
    rd_chk(`SRG_DIV_OFS);
    gap(1, g);
    gap(1, g);
    check("oversample 255", g, 256);
    repeat (100) @(posedge sys_clk);
    wr_reg(`SRG_DIV_OFS, 8'hFF, 4'h1);
    gap(1, g);
    check("restart on write", {31'h0, g >= 256 && g <= 257}, 1);
    // majority vote ignores a glitch of one timer period
    wr_reg(`SRG_DIV_OFS, 3, 4'h1);
    serial_receive_input <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check("rx low", {31'h0, rx_level}, 0);
    // glitch lasts one timer period so exactly one sample sees it
    serial_receive_input <= 1'b1;
    repeat (4) @(posedge sys_clk);
    serial_receive_input <= 1'b0;
    hits = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (rx_level !== 1'b0) hits++;
    end
    check("rx glitch", hits, 0);
    serial_receive_input <= 1'b1;
    repeat (40) @(posedge sys_clk);
    check("rx high", {31'h0, rx_level}, 1);
    // second reset in mid-run
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("mid reset", {waitrequest, bit_tick, oversample_tick, sclk_oe, txctl},
          {4'b1000, 8'h00});
    rst <= 1'b0;
    mdl_tx  = `SRG_TXCTL_RST;
    mdl_rx  = `SRG_RXCTL_RST;
    mdl_div = `SRG_DIV_RST;
    rd_chk(`SRG_DIV_OFS);
    rd_chk(`SRG_TXCTL_OFS);
    wrap_up();
  end

endmodule : srg_top_test

`default_nettype wire
